/* core/dcc_comparators.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - enabled raw output high when plus exceeds minus
// - disabled comparator output held low
// - raw output synchronised to form latched output
// - latched output readable, feeds interrupts, pin
// - raw output unclocked, to wakeup logic, pin
// - separate rising and falling edge flags
// - flags set regardless of interrupt enables
// - flags stay set until software clears
// - separate rise and fall interrupt enables
// - request needs flag, source and global enable
// - four response time modes per comparator
// - disabled comparator enters low power shutdown
// - positive hysteresis delays rising output
// - negative hysteresis delays falling output
// - two hysteresis fields, 20/10/5/0 mV
// - enable bit one to use, zero disables
// - input selects set by software per side
// - latched outputs routed to capture timers
// - input select registers at fixed addresses
module dcc_comparators (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic [7:0]                 sfr_addr,
	input  wire logic                       sfr_wr,
	input  wire logic                       sfr_rd,
	input  wire logic [7:0]                 sfr_wdata,
	output logic      [7:0]                 sfr_rdata,
	input  wire logic [1:0]                 compare_in,
	input  wire logic                       global_irq_enable,
	input  wire logic [1:0]                 irq_source_enable,
	output logic      [1:0]                 comparator_irq,
	output logic      [1:0]                 raw_output,
	output logic      [1:0]                 latched_output,
	output logic                            capture_timer_a_in,
	output logic                            capture_timer_b_in,
	output logic      [1:0]                 comparator_enable,
	output dcc_pkg::dcc_hyst_e [1:0]        pos_hysteresis_field,
	output dcc_pkg::dcc_hyst_e [1:0]        neg_hysteresis_field,
	output dcc_pkg::dcc_resp_e [1:0]        response_mode,
	output logic      [1:0][3:0]            positive_input_select,
	output logic      [1:0][3:0]            negative_input_select
);
	import dcc_pkg::*;

	typedef struct packed {
		logic [1:0]            en;
		dcc_hyst_e [1:0]       hyp;
		dcc_hyst_e [1:0]       hyn;
		dcc_resp_e [1:0]       rmode;
		logic [1:0]            rie;
		logic [1:0]            fie;
		logic [1:0][3:0]       psel;
		logic [1:0][3:0]       nsel;
		logic [1:0]            rif;
		logic [1:0]            fif;
		logic [1:0]            sync1;
		logic [1:0]            sync2;
		logic [1:0]            prev;
		logic [1:0]            irq;
		logic [7:0]            rdata;
	} dcc_state_s;

	dcc_state_s state_reg;
	dcc_state_s state_next;
	logic [1:0] rise_det;
	logic [1:0] fall_det;
	logic [1:0] wr_ctrl;
	logic [1:0] wr_mode;
	logic [1:0] wr_insel;

	// no clock in this path so wakeup works clock-stopped
	assign raw_output = compare_in & state_reg.en;

	assign rise_det = state_reg.sync2 & ~state_reg.prev;
	assign fall_det = ~state_reg.sync2 & state_reg.prev;

	always_comb begin
		for (int i = 0; i < DCC_NUM_CMP; i++) begin
			wr_ctrl[i]  = sfr_wr && (sfr_addr == DCC_CTRL_ADDR[i]);
			wr_mode[i]  = sfr_wr && (sfr_addr == DCC_MODE_ADDR[i]);
			wr_insel[i] = sfr_wr && (sfr_addr == DCC_INSEL_ADDR[i]);
		end
	end

	always_comb begin
		state_next       = state_reg;
		state_next.rdata = 8'h00;
		for (int i = 0; i < DCC_NUM_CMP; i++) begin
			// synchronise raw output to system clock
			// two stages, first read only by second
			state_next.sync1[i] = raw_output[i];
			state_next.sync2[i] = state_reg.sync1[i];
			state_next.prev[i]  = state_reg.sync2[i];

			if (wr_ctrl[i]) begin
				state_next.en[i]  = sfr_wdata[DCC_EN_BIT];
				state_next.hyp[i] =
					dcc_hyst_e'(sfr_wdata[DCC_HYP_LSB +: 2]);
				state_next.hyn[i] =
					dcc_hyst_e'(sfr_wdata[DCC_HYN_LSB +: 2]);
			end

			// only a write of zero clears; a same-cycle edge wins
			if (wr_ctrl[i]) begin
				state_next.rif[i] = sfr_wdata[DCC_RIF_BIT] | rise_det[i];
				state_next.fif[i] = sfr_wdata[DCC_FIF_BIT] | fall_det[i];
			end else begin
				state_next.rif[i] = state_reg.rif[i] | rise_det[i];
				state_next.fif[i] = state_reg.fif[i] | fall_det[i];
			end

			if (wr_mode[i]) begin
				state_next.rie[i]   = sfr_wdata[DCC_RIE_BIT];
				state_next.fie[i]   = sfr_wdata[DCC_FIE_BIT];
				state_next.rmode[i] =
					dcc_resp_e'(sfr_wdata[DCC_RMODE_LSB +: 2]);
			end

			// input selects, each side on its own
			if (wr_insel[i]) begin
				state_next.psel[i] = sfr_wdata[DCC_PSEL_LSB +: 4];
				state_next.nsel[i] = sfr_wdata[DCC_NSEL_LSB +: 4];
			end

			// flag gated by own enable, source and global
			state_next.irq[i] =
				((state_reg.rif[i] & state_reg.rie[i]) |
				 (state_reg.fif[i] & state_reg.fie[i])) &
				irq_source_enable[i] & global_irq_enable;

			// latched output readable in control register
			if (sfr_rd && sfr_addr == DCC_CTRL_ADDR[i]) begin
				state_next.rdata = {state_reg.en[i], state_reg.sync2[i],
					state_reg.rif[i], state_reg.fif[i],
					state_reg.hyp[i], state_reg.hyn[i]};
			end
			if (sfr_rd && sfr_addr == DCC_MODE_ADDR[i]) begin
				state_next.rdata = {2'h0, state_reg.rie[i],
					state_reg.fie[i], 2'h0, state_reg.rmode[i]};
			end
			if (sfr_rd && sfr_addr == DCC_INSEL_ADDR[i]) begin
				state_next.rdata = {state_reg.nsel[i],
					state_reg.psel[i]};
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg.en    <= {2{DCC_EN_RST}};
			state_reg.hyp   <= '{default: DCC_HYST_RST};
			state_reg.hyn   <= '{default: DCC_HYST_RST};
			state_reg.rmode <= '{default: DCC_RESP_RST};
			state_reg.rie   <= 2'h0;
			state_reg.fie   <= 2'h0;
			state_reg.psel  <= {2{DCC_SEL_RST}};
			state_reg.nsel  <= {2{DCC_SEL_RST}};
			state_reg.rif   <= 2'h0;
			state_reg.fif   <= 2'h0;
			state_reg.sync1 <= 2'h0;
			state_reg.sync2 <= 2'h0;
			state_reg.prev  <= 2'h0;
			state_reg.irq   <= 2'h0;
			state_reg.rdata <= DCC_RDATA_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sfr_rdata             = state_reg.rdata;
	assign comparator_irq        = state_reg.irq;
	assign latched_output        = state_reg.sync2;
	// latched outputs to the capture timers
	assign capture_timer_a_in    = state_reg.sync2[0];
	assign capture_timer_b_in    = state_reg.sync2[1];
	// enable low powers the analog stage down
	assign comparator_enable     = state_reg.en;
	assign pos_hysteresis_field  = state_reg.hyp;
	assign neg_hysteresis_field  = state_reg.hyn;
	assign response_mode         = state_reg.rmode;
	assign positive_input_select = state_reg.psel;
	assign negative_input_select = state_reg.nsel;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	raw_low_off_a: assert property (
		!comparator_enable[0] |-> !raw_output[0])
		else $error("raw output high while disabled");

	raw_follow_a: assert property (
		comparator_enable[1] |-> raw_output[1] == compare_in[1])
		else $error("raw output does not follow compare");

	sync_delay_a: assert property (
		##2 latched_output[0] == $past(raw_output[0], 2))
		else $error("latched output not two cycles behind");

	rise_flag_a: assert property (
		$rose(latched_output[0]) |=> state_reg.rif[0])
		else $error("rising edge did not set flag");

	fall_flag_a: assert property (
		$fell(latched_output[1]) |=> state_reg.fif[1] && 
		$stable(state_reg.rif[1]) || wr_ctrl[1] || $past(wr_ctrl[1]))
		else $error("falling edge flag wrong");

	flag_hold_a: assert property (
		state_reg.rif[0] && !wr_ctrl[0] |=> state_reg.rif[0])
		else $error("rise flag cleared without write");

	irq_gate_a: assert property (
		##1 comparator_irq[1] ==
		((($past(state_reg.rif[1]) & $past(state_reg.rie[1])) |
		 ($past(state_reg.fif[1]) & $past(state_reg.fie[1]))) &
		$past(irq_source_enable[1]) & $past(global_irq_enable)))
		else $error("interrupt request gating wrong");

	enable_write_a: assert property (
		wr_ctrl[0] |=> comparator_enable[0] == $past(sfr_wdata[7]))
		else $error("enable bit not written");

	insel_write_a: assert property (
		wr_insel[1] |=> negative_input_select[1] ==
		$past(sfr_wdata[7:4]))
		else $error("negative select not written");

	read_out_a: assert property (
		sfr_rd && sfr_addr == 8'h9B |=>
		sfr_rdata[6] == $past(latched_output[0]))
		else $error("output bit read wrong");

	raw_off_second_a: assert property (
		!comparator_enable[1] |-> !raw_output[1])
		else $error("second raw output high while disabled");

	raw_first_a: assert property (
		comparator_enable[0] |-> raw_output[0] == compare_in[0])
		else $error("first raw output does not follow compare");

	sync_second_a: assert property (
		##2 latched_output[1] == $past(raw_output[1], 2))
		else $error("second latched output not two cycles behind");

	timer_route_a: assert property (
		capture_timer_a_in == latched_output[0] &&
		capture_timer_b_in == latched_output[1])
		else $error("capture timer input not the latched output");

	rise_second_a: assert property (
		$rose(latched_output[1]) |=> state_reg.rif[1])
		else $error("second rising edge did not set flag");

	fall_first_a: assert property (
		$fell(latched_output[0]) |=> state_reg.fif[0])
		else $error("first falling edge did not set flag");

	fall_hold_a: assert property (
		state_reg.fif[1] && !wr_ctrl[1] |=> state_reg.fif[1])
		else $error("fall flag cleared without write");

	flag_on_edge_a: assert property (
		!state_reg.rif[0] && !wr_ctrl[0] &&
		!$rose(latched_output[0]) |=> !state_reg.rif[0])
		else $error("rise flag set without an edge");

	irq_enables_a: assert property (
		comparator_irq[0] |->
		$past(global_irq_enable) && $past(irq_source_enable[0]))
		else $error("request raised while interrupts disabled");

	rise_gate_a: assert property (
		comparator_irq[0] &&
		!($past(state_reg.fif[0]) && $past(state_reg.fie[0])) |->
		$past(state_reg.rif[0]) && $past(state_reg.rie[0]))
		else $error("request without an enabled flag");

	mode_write_a: assert property (
		wr_mode[0] |=> response_mode[0] == $past(sfr_wdata[1:0]))
		else $error("response mode not written");

	hyst_write_a: assert property (
		wr_ctrl[1] |=>
		pos_hysteresis_field[1] == $past(sfr_wdata[3:2]) &&
		neg_hysteresis_field[1] == $past(sfr_wdata[1:0]))
		else $error("hysteresis fields not written");

	psel_write_a: assert property (
		wr_insel[0] |=>
		positive_input_select[0] == $past(sfr_wdata[3:0]))
		else $error("positive select not written");

	enable_off_a: assert property (
		wr_ctrl[1] && !sfr_wdata[DCC_EN_BIT] |=>
		!comparator_enable[1])
		else $error("comparator not shut down by clearing enable");

	rise_cov: cover property ($rose(latched_output[0]));
	fall_cov: cover property ($fell(latched_output[1]));
	irq_cov:  cover property ($rose(comparator_irq[0]));
	clr_cov:  cover property (wr_ctrl[0] && rise_det[0]);
	fall_first_cov: cover property ($fell(latched_output[0]));

endmodule

/* core/dcc_pkg.sv */
package dcc_pkg;

	// special-function register addresses, index 0 is the first comparator
	localparam logic [1:0][7:0] DCC_CTRL_ADDR  = {8'h9A, 8'h9B};
	localparam logic [1:0][7:0] DCC_MODE_ADDR  = {8'h9C, 8'h9D};
	localparam logic [1:0][7:0] DCC_INSEL_ADDR = {8'h9E, 8'h9F};

	// comparator_control_reg fields
	localparam int DCC_EN_BIT     = 7;
	localparam int DCC_OUT_BIT    = 6;
	localparam int DCC_RIF_BIT    = 5;
	localparam int DCC_FIF_BIT    = 4;
	localparam int DCC_HYP_LSB    = 2;
	localparam int DCC_HYN_LSB    = 0;

	// comparator_mode_reg fields
	localparam int DCC_RIE_BIT    = 5;
	localparam int DCC_FIE_BIT    = 4;
	localparam int DCC_RMODE_LSB  = 0;

	// input select register fields
	localparam int DCC_NSEL_LSB   = 4;
	localparam int DCC_PSEL_LSB   = 0;

	// hysteresis amount per field setting
	typedef enum logic [1:0] {
		DCC_HYST_0MV  = 2'h0,
		DCC_HYST_5MV  = 2'h1,
		DCC_HYST_10MV = 2'h2,
		DCC_HYST_20MV = 2'h3
	} dcc_hyst_e;

	// response time, mode 0 fastest, mode 3 lowest power
	typedef enum logic [1:0] {
		DCC_RESP_MODE0 = 2'h0,
		DCC_RESP_MODE1 = 2'h1,
		DCC_RESP_MODE2 = 2'h2,
		DCC_RESP_MODE3 = 2'h3
	} dcc_resp_e;

	// values after reset
	localparam logic      DCC_EN_RST    = 1'h0;
	localparam dcc_hyst_e DCC_HYST_RST  = DCC_HYST_0MV;
	localparam dcc_resp_e DCC_RESP_RST  = DCC_RESP_MODE2;
	localparam logic [3:0] DCC_SEL_RST  = 4'hF;
	localparam logic [7:0] DCC_RDATA_RST = 8'h00;

	localparam int DCC_NUM_CMP   = 2;

endpackage

/* test/dcc_analog_model.sv */
`timescale 1ns/1ps
// far side: a comparator front end with hysteresis, levels in millivolts
module dcc_analog_model (
	input  wire logic [1:0]                 comparator_enable,
	input  wire dcc_pkg::dcc_hyst_e [1:0]   pos_hysteresis_field,
	input  wire dcc_pkg::dcc_hyst_e [1:0]   neg_hysteresis_field,
	input  wire logic [1:0][7:0]            pos_mv,
	input  wire logic [1:0][7:0]            neg_mv,
	output logic      [1:0]                 compare_in
);
	import dcc_pkg::*;
	logic [1:0] state_q = 2'h0;
	function automatic int amount(input dcc_hyst_e h);
		return (h == DCC_HYST_20MV) ? 20 : (h == DCC_HYST_10MV) ? 10 :
			(h == DCC_HYST_5MV) ? 5 : 0;
	endfunction
	always @* begin
		for (int i = 0; i < 2; i++) begin
			if (int'(pos_mv[i]) >
				int'(neg_mv[i]) + amount(pos_hysteresis_field[i]))
				state_q[i] = 1'b1;
			else if (int'(pos_mv[i]) +
				amount(neg_hysteresis_field[i]) < int'(neg_mv[i]))
				state_q[i] = 1'b0;
		end
	end
	// shut down comparator gives no meaningful level
	assign compare_in = (state_q & comparator_enable) |
		(~state_q & ~comparator_enable);
endmodule

/* test/dual_comparator_control_bench.sv */
`timescale 1ns/1ps
module dual_comparator_control_bench;
	import dcc_pkg::*;
	logic            clk, reset, sfr_wr, sfr_rd, global_irq_enable;
	logic [7:0]      sfr_addr, sfr_wdata, sfr_rdata;
	logic [1:0]      compare_in, irq_src, irq, raw, latched, enable;
	logic            cap_a, cap_b;
	dcc_hyst_e [1:0] hyp, hyn;
	dcc_resp_e [1:0] resp;
	logic [1:0][3:0] psel, nsel;
	logic [1:0][7:0] pos_mv, neg_mv;
	int              err_total, tests_run;

	dcc_comparators dut_u (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .compare_in(compare_in),
		.global_irq_enable(global_irq_enable), .irq_source_enable(irq_src),
		.comparator_irq(irq), .raw_output(raw), .latched_output(latched),
		.capture_timer_a_in(cap_a), .capture_timer_b_in(cap_b),
		.comparator_enable(enable), .pos_hysteresis_field(hyp),
		.neg_hysteresis_field(hyn), .response_mode(resp),
		.positive_input_select(psel), .negative_input_select(nsel));
	dcc_analog_model model_u (.comparator_enable(enable),
		.pos_hysteresis_field(hyp), .neg_hysteresis_field(hyn),
		.pos_mv(pos_mv), .neg_mv(neg_mv), .compare_in(compare_in));

	always #2.5 clk = ~clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'b1; sfr_addr <= a; sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		sfr_rd <= 1'b1; sfr_addr <= a;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 chk(sfr_rdata, exp);
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		for (int i = 0; i < 2; i++) begin
			rd(DCC_CTRL_ADDR[i], 8'h00);
			rd(DCC_MODE_ADDR[i], 8'h02);
			rd(DCC_INSEL_ADDR[i], 8'hFF);
		end
		rd(8'h90, 8'h00);
		$display("test reset values done");
	endtask
	task automatic t_edges();
		pos_mv[0] <= 8'h64; neg_mv[0] <= 8'h32;
		wr(8'h9D, 8'h20);
		chk({6'h0, resp[0]}, 8'h00);
		wr(8'h9B, 8'h80);
		chk(raw, 8'h01);
		step(); chk(latched, 8'h00);
		step(); chk(latched, 8'h01);
		chk(cap_a, 8'h01);
		step(); step(); chk(irq, 8'h01);
		rd(8'h9B, 8'hE0);
		@(posedge clk) global_irq_enable <= 1'b0;
		step(); step(); chk(irq, 8'h00);
		wr(8'h9B, 8'hC0);
		rd(8'h9B, 8'hC0);
		@(posedge clk) global_irq_enable <= 1'b1;
		pos_mv[0] <= 8'h00;
		repeat (6) step();
		rd(8'h9B, 8'h90);
		chk(irq, 8'h00);
		// output high again so that disabling makes a falling edge
		pos_mv[0] <= 8'h64;
		repeat (4) step();
		wr(8'h9B, 8'h00);
		chk(raw, 8'h00);
		repeat (4) step();
		rd(8'h9B, 8'h10);
		wr(8'h9B, 8'h00);
		$display("test edges and flags done");
	endtask
	task automatic t_hyst();
		// settings before pos_mv[1] moves, so its steps never meet 0 mV hysteresis
		neg_mv[1] <= 8'h32;
		wr(8'h9A, 8'h8E);
		wr(8'h9A, 8'h8E);
		chk({4'h0, hyp[1], hyn[1]}, 8'h0E);
		pos_mv[1] <= 8'h3C;
		repeat (4) step(); chk(latched, 8'h00);
		pos_mv[1] <= 8'h50;
		step(); chk(raw, 8'h02);
		repeat (3) step(); chk(cap_b, 8'h01);
		$display("test hysteresis done");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			wr(8'h9C, 8'(m));
			chk({6'h0, resp[1]}, 8'(m));
		end
		wr(8'h9E, 8'h5A);
		chk({nsel[1], psel[1]}, 8'h5A);
		wr(8'h9F, 8'hC3);
		rd(8'h9F, 8'hC3);
		$display("test modes and selects done");
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#20000;
		err_total++;
		test_done();
	end
	initial begin
		clk = 0; reset = 1; sfr_wr = 0; sfr_rd = 0; sfr_addr = 0;
		sfr_wdata = 0; global_irq_enable = 1; irq_src = 2'h3;
		pos_mv = '0; neg_mv = '0; err_total = 0; tests_run = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_edges();
		t_hyst();
		t_modes();
		test_done();
	end
endmodule
